// file: hw/nac_defs.svh
`ifndef NAC_DEFS_SVH
`define NAC_DEFS_SVH

// ==========================================================
// widths
`define NAC_NIB_W        4
`define NAC_D_W          3
`define NAC_PAGE_W       7
`define NAC_ROM_W        10
`define NAC_ROM_ADDR_W   14
`define NAC_OPND_W       4

// ==========================================================
// field positions in a fetched rom word
`define NAC_ROM_HI_MSB   7
`define NAC_ROM_HI_LSB   4
`define NAC_ROM_LO_MSB   3
`define NAC_ROM_LO_LSB   0
`define NAC_ROM_UP_MSB   9
`define NAC_ROM_UP_LSB   8

// ==========================================================
// reset values
`define NAC_ACC_RST      4'h0
`define NAC_B_RST        4'h0
`define NAC_D_RST        3'h0
`define NAC_CARRY_RST    1'b0
`define NAC_WDATA_RST    4'h0
`define NAC_ROM_ADDR_RST 14'h0000

`endif

// file: hw/nac_pkg.sv
`include "nac_defs.svh"

package nac_pkg;

    // ==========================================================
    // operations issued by the sequencer
    typedef enum logic [3:0] {
        NAC_OP_NOP,
        NAC_OP_LOAD_IMM,
        NAC_OP_TABLE_FETCH,
        NAC_OP_ADD_MEM,
        NAC_OP_ADD_MEM_CARRY,
        NAC_OP_ADD_IMM,
        NAC_OP_AND,
        NAC_OP_OR,
        NAC_OP_SET_CARRY,
        NAC_OP_CLR_CARRY,
        NAC_OP_SKIP_CARRY_ZERO,
        NAC_OP_COMPLEMENT,
        NAC_OP_ROTATE_RIGHT,
        NAC_OP_BIT_SET,
        NAC_OP_BIT_CLEAR,
        NAC_OP_LOAD_D
    } nac_opcode_type;

    typedef enum logic [0:0] {
        NAC_ST_IDLE,
        NAC_ST_TABLE_WAIT
    } nac_fsm_type;

    typedef struct packed {
        nac_opcode_type               opcode;
        logic [`NAC_OPND_W-1:0]       operand;
        logic [`NAC_PAGE_W-1:0]       page;
    } nac_op_type;

    typedef struct packed {
        nac_fsm_type                  fsm;
        logic [`NAC_NIB_W-1:0]        acc;
        logic [`NAC_NIB_W-1:0]        reg_b;
        logic [`NAC_D_W-1:0]          reg_d;
        logic                         carry_flag;
        logic                         skip_pending;
        logic                         last_load_imm;
        logic                         ram_we;
        logic [`NAC_NIB_W-1:0]        ram_wdata;
        logic                         rom_rd;
        logic [`NAC_ROM_ADDR_W-1:0]   rom_addr;
        logic                         stack_push;
        logic                         stack_pop;
        logic                         busy;
        logic                         slot_skipped;
    } nac_state_type;

endpackage

// file: hw/nac_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "nac_defs.svh"

module nac_alu (
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          op_valid_in,
    input  wire nac_pkg::nac_op_type           op_in,
    input  wire logic                          upper_table_flag_in,
    input  wire logic [`NAC_NIB_W-1:0]         addressed_ram_nibble_in,
    input  wire logic [`NAC_ROM_W-1:0]         rom_data_in,
    output var  logic [`NAC_NIB_W-1:0]         acc_out,
    output var  logic [`NAC_NIB_W-1:0]         reg_b_out,
    output var  logic [`NAC_D_W-1:0]           table_pointer_bits_out,
    output var  logic                          carry_flag_out,
    output var  logic                          skip_next_out,
    output var  logic                          slot_skipped_out,
    output var  logic                          ram_we_out,
    output var  logic [`NAC_NIB_W-1:0]         ram_wdata_out,
    output var  logic                          rom_rd_out,
    output var  logic [`NAC_ROM_ADDR_W-1:0]    rom_addr_out,
    output var  logic                          return_stack_push_out,
    output var  logic                          return_stack_pop_out,
    output var  logic                          busy_out
);
    import nac_pkg::*;

    // ==========================================================
    // state
    nac_state_type s_reg;
    nac_state_type s_next;

    // ==========================================================
    // datapath helpers
    logic [`NAC_NIB_W:0]   sum_mem;
    logic [`NAC_NIB_W:0]   sum_mem_carry;
    logic [`NAC_NIB_W:0]   sum_imm;
    logic [`NAC_NIB_W-1:0] and_res;
    logic [`NAC_NIB_W-1:0] or_res;
    logic [`NAC_NIB_W-1:0] cmp_res;
    logic [`NAC_NIB_W-1:0] rot_acc;
    logic                  rot_carry;
    logic [`NAC_NIB_W-1:0] bit_mask;
    logic [`NAC_NIB_W-1:0] bit_set_data;
    logic [`NAC_NIB_W-1:0] bit_clr_data;
    logic [`NAC_NIB_W-1:0] rom_hi;
    logic [`NAC_NIB_W-1:0] rom_lo;
    logic [1:0]            rom_up;
    logic                  is_load_imm;
    logic                  take_slot;
    logic                  do_skip;

    // ==========================================================
    // adders
    // one adder per flavour, so no carry out leaks into another op
    always_comb begin
        sum_mem       = {1'b0, s_reg.acc} + {1'b0, addressed_ram_nibble_in};
        sum_mem_carry = sum_mem + {{`NAC_NIB_W{1'b0}}, s_reg.carry_flag};
        sum_imm       = {1'b0, s_reg.acc} + {1'b0, op_in.operand};
    end

    // ==========================================================
    // logic, complement and rotate results
    assign and_res   = s_reg.acc & addressed_ram_nibble_in;
    assign or_res    = s_reg.acc | addressed_ram_nibble_in;
    assign cmp_res   = ~s_reg.acc;
    // acc bit 0 drops into carry
    assign rot_acc   = {s_reg.carry_flag, s_reg.acc[`NAC_NIB_W-1:1]};
    assign rot_carry = s_reg.acc[0];

    // ==========================================================
    // bit select and write data
    // one select per nibble bit, so the other bits pass through untouched
    generate
        for (genvar gi = 0; gi < `NAC_NIB_W; gi++) begin : g_bit
            assign bit_mask[gi]     = (op_in.operand[1:0] == 2'(gi));
            assign bit_set_data[gi] = addressed_ram_nibble_in[gi] | bit_mask[gi];
            assign bit_clr_data[gi] = addressed_ram_nibble_in[gi] & ~bit_mask[gi];
        end
    endgenerate

    // ==========================================================
    // rom word fields
    // high nibble to b, low nibble to acc
    assign rom_hi = rom_data_in[`NAC_ROM_HI_MSB:`NAC_ROM_HI_LSB];
    assign rom_lo = rom_data_in[`NAC_ROM_LO_MSB:`NAC_ROM_LO_LSB];
    assign rom_up = rom_data_in[`NAC_ROM_UP_MSB:`NAC_ROM_UP_LSB];

    // ==========================================================
    // slot acceptance
    // new ops are refused while a table fetch is outstanding
    assign take_slot   = op_valid_in && (s_reg.fsm == NAC_ST_IDLE);
    assign is_load_imm = (op_in.opcode == NAC_OP_LOAD_IMM);
    assign do_skip     = s_reg.skip_pending || (is_load_imm && s_reg.last_load_imm);

    // ==========================================================
    // next state
    always_comb begin
        s_next            = s_reg;
        s_next.ram_we     = 1'b0;
        s_next.rom_rd     = 1'b0;
        s_next.stack_push = 1'b0;
        s_next.stack_pop  = 1'b0;
        s_next.slot_skipped = 1'b0;

        case (s_reg.fsm)
            NAC_ST_IDLE: begin
                if (take_slot) begin
                    // every slot clears a pending skip, and tracks load chains
                    s_next.skip_pending  = 1'b0;
                    s_next.last_load_imm = (op_in.opcode == NAC_OP_LOAD_IMM);
                    if (do_skip) begin
                        s_next.slot_skipped = 1'b1;
                    end else begin
                        case (op_in.opcode)
                            NAC_OP_NOP: begin
                                // nop only uses up the slot
                                s_next.acc = s_reg.acc;
                            end

                            NAC_OP_LOAD_IMM: begin
                                s_next.acc = op_in.operand;
                            end

                            NAC_OP_TABLE_FETCH: begin
                                s_next.rom_addr   = {op_in.page, s_reg.reg_d, s_reg.acc};
                                s_next.rom_rd     = 1'b1;
                                s_next.stack_push = 1'b1;
                                s_next.busy       = 1'b1;
                                s_next.fsm        = NAC_ST_TABLE_WAIT;
                            end

                            NAC_OP_ADD_MEM: begin
                                s_next.acc = sum_mem[`NAC_NIB_W-1:0];
                            end

                            NAC_OP_ADD_MEM_CARRY: begin
                                s_next.acc        = sum_mem_carry[`NAC_NIB_W-1:0];
                                s_next.carry_flag = sum_mem_carry[`NAC_NIB_W];
                            end

                            NAC_OP_ADD_IMM: begin
                                s_next.acc          = sum_imm[`NAC_NIB_W-1:0];
                                s_next.skip_pending = ~sum_imm[`NAC_NIB_W];
                            end

                            NAC_OP_AND: begin
                                s_next.acc = and_res;
                            end

                            NAC_OP_OR: begin
                                s_next.acc = or_res;
                            end

                            NAC_OP_SET_CARRY: begin
                                s_next.carry_flag = 1'b1;
                            end

                            NAC_OP_CLR_CARRY: begin
                                s_next.carry_flag = 1'b0;
                            end

                            NAC_OP_SKIP_CARRY_ZERO: begin
                                s_next.skip_pending = ~s_reg.carry_flag;
                            end

                            NAC_OP_COMPLEMENT: begin
                                s_next.acc = cmp_res;
                            end

                            NAC_OP_ROTATE_RIGHT: begin
                                s_next.acc        = rot_acc;
                                s_next.carry_flag = rot_carry;
                            end

                            NAC_OP_BIT_SET: begin
                                s_next.ram_wdata = bit_set_data;
                                s_next.ram_we    = 1'b1;
                            end

                            NAC_OP_BIT_CLEAR: begin
                                s_next.ram_wdata = bit_clr_data;
                                s_next.ram_we    = 1'b1;
                            end

                            NAC_OP_LOAD_D: begin
                                // d pointer load for later table fetches
                                s_next.reg_d = op_in.operand[`NAC_D_W-1:0];
                            end

                            default: begin
                                s_next.acc = s_reg.acc;
                            end
                        endcase
                    end
                end else begin
                    // no slot this cycle: pulses drop, all else holds
                    s_next.skip_pending = s_reg.skip_pending;
                end
            end
            NAC_ST_TABLE_WAIT: begin
                // rom answers in the same cycle as the read strobe
                // ops offered now are lost, so the sequencer must hold them
                // high and low nibbles
                s_next.reg_b = rom_hi;
                s_next.acc   = rom_lo;
                if (upper_table_flag_in) begin
                    s_next.reg_d = {1'b0, rom_up};
                end
                s_next.stack_pop = 1'b1;
                s_next.busy      = 1'b0;
                s_next.fsm       = NAC_ST_IDLE;
            end
            default: begin
                s_next.fsm  = NAC_ST_IDLE;
                s_next.busy = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // registers
    // every field resets to a constant, never to an input
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg.fsm           <= NAC_ST_IDLE;
            s_reg.acc           <= `NAC_ACC_RST;
            s_reg.reg_b         <= `NAC_B_RST;
            s_reg.reg_d         <= `NAC_D_RST;
            s_reg.carry_flag    <= `NAC_CARRY_RST;
            s_reg.skip_pending  <= 1'b0;
            s_reg.last_load_imm <= 1'b0;
            s_reg.ram_we        <= 1'b0;
            s_reg.ram_wdata     <= `NAC_WDATA_RST;
            s_reg.rom_rd        <= 1'b0;
            s_reg.rom_addr      <= `NAC_ROM_ADDR_RST;
            s_reg.stack_push    <= 1'b0;
            s_reg.stack_pop     <= 1'b0;
            s_reg.busy          <= 1'b0;
            s_reg.slot_skipped  <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs straight from state
    assign acc_out                = s_reg.acc;
    assign reg_b_out              = s_reg.reg_b;
    assign table_pointer_bits_out = s_reg.reg_d;
    assign carry_flag_out         = s_reg.carry_flag;
    assign skip_next_out          = s_reg.skip_pending;
    assign slot_skipped_out       = s_reg.slot_skipped;
    assign ram_we_out             = s_reg.ram_we;
    assign ram_wdata_out          = s_reg.ram_wdata;
    assign rom_rd_out             = s_reg.rom_rd;
    assign rom_addr_out           = s_reg.rom_addr;
    assign return_stack_push_out  = s_reg.stack_push;
    assign return_stack_pop_out   = s_reg.stack_pop;
    assign busy_out               = s_reg.busy;

endmodule
`default_nettype wire

// file: verification/nac_alu_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker
module nac_alu_props (
    input wire logic               sys_clk_in, rst_n_in, op_valid_in, busy_out,
    input wire logic               upper_table_flag_in, carry_flag_out, skip_next_out,
    input wire logic               slot_skipped_out, ram_we_out, rom_rd_out,
    input wire logic               return_stack_push_out, return_stack_pop_out,
    input wire nac_pkg::nac_op_type op_in,
    input wire logic [3:0]         addressed_ram_nibble_in, acc_out, reg_b_out, ram_wdata_out,
    input wire logic [2:0]         table_pointer_bits_out,
    input wire logic [9:0]         rom_data_in,
    input wire logic [13:0]        rom_addr_out
);
    import nac_pkg::*;
    logic        tk;
    logic [4:0]  isum;
    logic [4:0]  csum;
    logic [3:0]  bset;
    logic [13:0] xaddr;
    // a pending skip eats the slot, so only clean slots count
    assign tk    = op_valid_in && !busy_out && !skip_next_out;
    assign isum  = {1'b0, acc_out} + {1'b0, op_in.operand};
    assign csum  = {1'b0, acc_out} + {1'b0, addressed_ram_nibble_in} + {4'h0, carry_flag_out};
    assign bset  = addressed_ram_nibble_in | (4'h1 << op_in.operand[1:0]);
    assign xaddr = {op_in.page, table_pointer_bits_out, acc_out};
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_issue; rom_rd_out && return_stack_push_out && busy_out; endsequence
    sequence s_done; return_stack_pop_out && !busy_out; endsequence
    property p_fetch_stack; tk && op_in.opcode == NAC_OP_TABLE_FETCH |=> s_issue ##1 s_done; endproperty
    a_fetch_stack: assert property (p_fetch_stack) else $error("fetch stack use wrong");
    property p_fetch_addr; tk && op_in.opcode == NAC_OP_TABLE_FETCH |=> rom_addr_out == $past(xaddr); endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
    property p_split; rom_rd_out |=> reg_b_out == $past(rom_data_in[7:4]) && acc_out == $past(rom_data_in[3:0])
        && (!$past(upper_table_flag_in) || table_pointer_bits_out == {1'b0, $past(rom_data_in[9:8])}); endproperty
    a_split: assert property (p_split) else $error("fetch split wrong");
    property p_addc; tk && op_in.opcode == NAC_OP_ADD_MEM_CARRY |=> {carry_flag_out, acc_out} == $past(csum); endproperty
    a_addc: assert property (p_addc) else $error("add with carry wrong");
    property p_addi; tk && op_in.opcode == NAC_OP_ADD_IMM |=> acc_out == $past(isum[3:0])
        && skip_next_out == !$past(isum[4]) && $stable(carry_flag_out); endproperty
    a_addi: assert property (p_addi) else $error("add immediate wrong");
    property p_szc; tk && op_in.opcode == NAC_OP_SKIP_CARRY_ZERO |=> skip_next_out == !$past(carry_flag_out) && $stable(carry_flag_out); endproperty
    a_szc: assert property (p_szc) else $error("carry skip wrong");
    property p_skipped; op_valid_in && !busy_out && skip_next_out |=> slot_skipped_out && !skip_next_out
        && $stable(acc_out) && $stable(carry_flag_out) && !ram_we_out && !rom_rd_out; endproperty
    a_skipped: assert property (p_skipped) else $error("skipped slot had effect");
    property p_bset; tk && op_in.opcode == NAC_OP_BIT_SET |=> ram_we_out && ram_wdata_out == $past(bset); endproperty
    a_bset: assert property (p_bset) else $error("bit set wrong");
endmodule
bind nac_alu nac_alu_props nac_alu_props_inst (.*);
`default_nettype wire

// file: verification/nac_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// rom and data ram seen by the block
module nac_far_model (
    input  wire logic        sys_clk_in,
    input  wire logic        load_in,
    input  wire logic [3:0]  load_val_in,
    input  wire logic        ram_we_out,
    input  wire logic [3:0]  ram_wdata_out,
    input  wire logic        rom_rd_out,
    input  wire logic [13:0] rom_addr_out,
    output var  logic [3:0]  nibble_out,
    output var  logic [9:0]  rom_word_out
);
    logic [9:0] word;
    assign word = {rom_addr_out[1:0], rom_addr_out[7:0] ^ 8'h5a};
    // outside a read the word is inverted so stale data cannot pass
    assign rom_word_out = rom_rd_out ? word : ~word;
    always @(posedge sys_clk_in) begin
        if (load_in) nibble_out <= load_val_in;
        else if (ram_we_out) nibble_out <= ram_wdata_out;
    end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import nac_pkg::*;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, op_valid_in = 1'b0, upper_table_flag_in = 1'b0;
    logic load_in = 1'b0;
    logic [3:0] load_val_in = 4'h0;
    nac_op_type op_in = '0;
    logic [3:0] addressed_ram_nibble_in, acc_out, reg_b_out, ram_wdata_out;
    logic [9:0] rom_data_in;
    logic [2:0] table_pointer_bits_out;
    logic [13:0] rom_addr_out;
    logic carry_flag_out, skip_next_out, slot_skipped_out, ram_we_out, rom_rd_out;
    logic return_stack_push_out, return_stack_pop_out, busy_out;
    int failures = 0, checked = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    nac_alu nac_alu_inst (.*);
    nac_far_model nac_far_model_inst (.nibble_out(addressed_ram_nibble_in),
        .rom_word_out(rom_data_in), .*);
    // ==========================================================
    // helpers
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits out busy so a slot is never lost
    task automatic op(input nac_opcode_type oc, input logic [3:0] n, input logic [6:0] pg = 7'h0);
        @(negedge sys_clk_in);
        op_valid_in = 1'b1;
        op_in = '{oc, n, pg};
        @(negedge sys_clk_in);
        op_valid_in = 1'b0;
        while (busy_out === 1'b1) @(negedge sys_clk_in);
    endtask
    task automatic ram(input logic [3:0] v);
        @(negedge sys_clk_in);
        load_in = 1'b1;
        load_val_in = v;
        @(negedge sys_clk_in);
        load_in = 1'b0;
    endtask
    task automatic end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_logic;
        ram(4'ha); op(NAC_OP_LOAD_IMM, 4'hc); chk(acc_out, 4'hc);
        op(NAC_OP_AND, 4'h0); chk(acc_out, 4'h8);
        ram(4'h5); op(NAC_OP_OR, 4'h0); chk(acc_out, 4'hd);
        op(NAC_OP_COMPLEMENT, 4'h0); chk(acc_out, 4'h2);
        $display("test logic done");
    endtask
    task automatic t_carry;
        op(NAC_OP_SET_CARRY, 4'h0); chk({carry_flag_out, acc_out}, 5'h12);
        ram(4'hf); op(NAC_OP_ADD_MEM_CARRY, 4'h0); chk({carry_flag_out, acc_out}, 5'h12);
        op(NAC_OP_ADD_MEM, 4'h0); chk({carry_flag_out, acc_out}, 5'h11);
        op(NAC_OP_ROTATE_RIGHT, 4'h0); chk({carry_flag_out, acc_out}, 5'h18);
        op(NAC_OP_CLR_CARRY, 4'h0); chk({carry_flag_out, acc_out}, 5'h08);
        op(NAC_OP_ROTATE_RIGHT, 4'h0); chk({carry_flag_out, acc_out}, 5'h04);
        $display("test carry done");
    endtask
    task automatic t_skip;
        op(NAC_OP_LOAD_IMM, 4'h3); op(NAC_OP_LOAD_IMM, 4'h7);
        chk({slot_skipped_out, acc_out}, 5'h13);
        op(NAC_OP_ADD_IMM, 4'h1); chk({skip_next_out, acc_out}, 5'h14);
        op(NAC_OP_COMPLEMENT, 4'h0); chk({slot_skipped_out, acc_out}, 5'h14);
        op(NAC_OP_ADD_IMM, 4'hd); chk({carry_flag_out, skip_next_out, acc_out}, 6'h01);
        op(NAC_OP_SKIP_CARRY_ZERO, 4'h0); chk(skip_next_out, 1'b1);
        op(NAC_OP_SET_CARRY, 4'h0); chk(carry_flag_out, 1'b0);
        op(NAC_OP_SET_CARRY, 4'h0); op(NAC_OP_SKIP_CARRY_ZERO, 4'h0);
        chk({carry_flag_out, skip_next_out}, 2'b10);
        $display("test skip done");
    endtask
    task automatic t_table;
        op(NAC_OP_LOAD_D, 4'h5); op(NAC_OP_LOAD_IMM, 4'h6); upper_table_flag_in = 1'b1;
        op(NAC_OP_TABLE_FETCH, 4'h0, 7'h2b); chk(rom_addr_out, {7'h2b, 3'h5, 4'h6});
        chk({reg_b_out, acc_out, table_pointer_bits_out}, 11'h462);
        upper_table_flag_in = 1'b0;
        op(NAC_OP_TABLE_FETCH, 4'h0, 7'h01); chk(rom_addr_out, {7'h01, 3'h2, 4'hc});
        chk({reg_b_out, acc_out, table_pointer_bits_out}, 11'h7b2);
        $display("test table done");
    endtask
    task automatic t_bits;
        ram(4'h1); op(NAC_OP_BIT_SET, 4'h2); chk({ram_we_out, ram_wdata_out}, 5'h15);
        op(NAC_OP_BIT_CLEAR, 4'h0); chk({ram_we_out, ram_wdata_out}, 5'h14);
        op(NAC_OP_BIT_CLEAR, 4'h3); chk({ram_we_out, ram_wdata_out}, 5'h14);
        $display("test bits done");
    endtask
    // ==========================================================
    // main and watchdog
    initial begin
        repeat (5) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        chk({acc_out, reg_b_out, table_pointer_bits_out, carry_flag_out}, 12'h000);
        t_logic; t_carry; t_skip; t_table; t_bits;
        end_sim;
    end
    initial begin
        #100000;
        failures++;
        end_sim;
    end
endmodule
`default_nettype wire
